// file: hdl/tacr_pkg.sv
package tacr_pkg;

	// ----------------------------------------------------------------
	// Register indices and byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0]  IDX_CFG_ONE  = 8'h9a;
	localparam logic [7:0]  IDX_CFG_TWO  = 8'h9c;
	localparam logic [11:0] ADDR_CFG_ONE = {2'h0, IDX_CFG_ONE, 2'h0};
	localparam logic [11:0] ADDR_CFG_TWO = {2'h0, IDX_CFG_TWO, 2'h0};

	// ----------------------------------------------------------------
	// Reset values and unmapped read data
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_CFG_ONE  = 32'h0000_0000;
	localparam logic [31:0] RST_CFG_TWO  = 32'h0020_0000;
	localparam logic [31:0] RD_UNMAPPED  = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Field positions of the first configuration word
	// ----------------------------------------------------------------
	localparam int POS_PARITY    = 31;
	localparam int POS_HANDOFF   = 22;
	localparam int POS_NEG_LIM   = 16;
	localparam int POS_HYST      = 15;
	localparam int POS_BEMF      = 10;
	localparam int POS_ISD_CYC   = 7;
	localparam int POS_ZC_ANGLE  = 2;
	localparam int POS_FS_DIV    = 0;

	// ----------------------------------------------------------------
	// Field scaling constants
	// ----------------------------------------------------------------
	localparam logic [7:0] BEMF_STEP     = 8'hc8;
	localparam logic [4:0] ISD_CYC_BASE  = 5'h02;
	localparam logic [4:0] ISD_CYC_STEP  = 5'h03;
	localparam logic [6:0] HYST_WIDE     = 7'h14;
	localparam logic [6:0] HYST_NARROW   = 7'h0a;

endpackage

// file: hdl/tacr_field_decode.sv
`timescale 1ns/1ps

module tacr_field_decode (
	input  wire logic [31:0]       cfg_word,
	output logic [4:0]             open_loop_handoff_count,
	output logic signed [6:0]      surge_negative_current_limit,
	output logic signed [6:0]      surge_positive_current_limit,
	output logic [12:0]            speed_detect_backemf_threshold,
	output logic [4:0]             speed_detect_cycle_threshold,
	output logic [3:0]             zero_cross_open_loop_angle,
	output logic [1:0]             fast_startup_rate_shift
);

	// ----------------------------------------------------------------
	// Lookup functions
	// ----------------------------------------------------------------
	function automatic logic [4:0] handoff_lut(input logic [1:0] code);
		logic [4:0] val;
		val = 5'h03 << code;
		return val;
	endfunction

	function automatic logic signed [6:0] neg_lut(input logic [2:0] code);
		logic signed [6:0] val;
		case (code)
			3'h0: val = 7'sd0;
			3'h1: val = -7'sd40;
			3'h2: val = -7'sd30;
			3'h3: val = -7'sd20;
			3'h4: val = -7'sd10;
			3'h5: val = 7'sd10;
			3'h6: val = 7'sd20;
			default: val = 7'sd30;
		endcase
		return val;
	endfunction

	function automatic logic [3:0] angle_lut(input logic [1:0] code);
		logic [3:0] val;
		case (code)
			2'h0: val = 4'h5;
			2'h1: val = 4'h8;
			2'h2: val = 4'hc;
			default: val = 4'hf;
		endcase
		return val;
	endfunction

	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------
	logic [6:0] hyst;
	logic [7:0] pos_sum;

	always_comb begin
		open_loop_handoff_count = handoff_lut(cfg_word[tacr_pkg::POS_HANDOFF +: 2]);
		surge_negative_current_limit = neg_lut(cfg_word[tacr_pkg::POS_NEG_LIM +: 3]);
		hyst = cfg_word[tacr_pkg::POS_HYST] ? tacr_pkg::HYST_NARROW
			: tacr_pkg::HYST_WIDE;
		pos_sum = {surge_negative_current_limit[6], surge_negative_current_limit}
			+ {1'b0, hyst};
		surge_positive_current_limit = pos_sum[6:0];
		speed_detect_backemf_threshold = 13'(cfg_word[tacr_pkg::POS_BEMF +: 5]
			* tacr_pkg::BEMF_STEP);
		speed_detect_cycle_threshold = tacr_pkg::ISD_CYC_BASE
			+ 5'(cfg_word[tacr_pkg::POS_ISD_CYC +: 3] * tacr_pkg::ISD_CYC_STEP);
		zero_cross_open_loop_angle = angle_lut(cfg_word[tacr_pkg::POS_ZC_ANGLE +: 2]);
		fast_startup_rate_shift = cfg_word[tacr_pkg::POS_FS_DIV +: 2];
	end

endmodule

// file: hdl/tacr_regs.sv
// The APB register port was decided locally.
`timescale 1ns/1ps

// Functional notes
// - Handoff code selects 3, 6, 12, 24 cycles
// - Negative surge limit code maps to counts
// - Positive limit is hysteresis plus negative limit
// - Back-EMF threshold is 200 times field
// - Cycle threshold is two plus three times code
// - Open-loop zero-cross only above selected angle
// - Fast-startup rate divided by 1, 2, 4, 8
// - Second word resets to 0x00200000

module tacr_regs #(
	parameter int ADDR_W = 12,
	parameter int RATE_W = 16
) (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  ce,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_W-1:0]     paddr,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  open_loop_active,
	input  wire logic [7:0]            rotor_angle_deg,
	input  wire logic [RATE_W-1:0]     coeff_rate_in,
	output logic [31:0]                trap_algorithm_config_one,
	output logic [31:0]                trap_algorithm_config_two,
	output logic [4:0]                 open_loop_handoff_count,
	output logic signed [6:0]          surge_negative_current_limit,
	output logic signed [6:0]          surge_positive_current_limit,
	output logic [12:0]                speed_detect_backemf_threshold,
	output logic [4:0]                 speed_detect_cycle_threshold,
	output logic [3:0]                 zero_cross_open_loop_angle,
	output logic [3:0]                 fast_startup_rate_divisor,
	output logic                       zero_crossing_enable,
	output logic [RATE_W-1:0]          coeff_rate_scaled
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (ADDR_W < 10 || ADDR_W > 12) begin : g_chk_addr
		$error("ADDR_W must be 10 to 12");
	end
	if (RATE_W < 4) begin : g_chk_rate
		$error("RATE_W must be at least 4");
	end

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic [1:0] decode(input logic [ADDR_W-1:0] addr);
		logic [1:0] sel;
		sel = 2'h0;
		if (addr == ADDR_W'(tacr_pkg::ADDR_CFG_ONE)) begin
			sel = 2'h1;
		end else if (addr == ADDR_W'(tacr_pkg::ADDR_CFG_TWO)) begin
			sel = 2'h2;
		end
		return sel;
	endfunction

	// ----------------------------------------------------------------
	// Decoded fields of the first word
	// ----------------------------------------------------------------
	logic [4:0]        dec_handoff;
	logic signed [6:0] dec_neg;
	logic signed [6:0] dec_pos;
	logic [12:0]       dec_bemf;
	logic [4:0]        dec_cyc;
	logic [3:0]        dec_angle;
	logic [1:0]        dec_shift;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [31:0]        cfg_one_ff,   nxt_cfg_one;
	logic [31:0]        cfg_two_ff,   nxt_cfg_two;
	logic [31:0]        prdata_ff,    nxt_prdata;
	logic               pready_ff,    nxt_pready;
	logic               pslverr_ff,   nxt_pslverr;
	logic [4:0]         handoff_ff,   nxt_handoff;
	logic signed [6:0]  neg_ff,       nxt_neg;
	logic signed [6:0]  pos_ff,       nxt_pos;
	logic [12:0]        bemf_ff,      nxt_bemf;
	logic [4:0]         cyc_ff,       nxt_cyc;
	logic [3:0]         angle_ff,     nxt_angle;
	logic [3:0]         div_ff,       nxt_div;
	logic               zc_en_ff,     nxt_zc_en;
	logic [RATE_W-1:0]  rate_ff,      nxt_rate;
	logic [1:0]         sel;
	logic               setup;
	logic               access;

	tacr_field_decode u_decode (
		.cfg_word                       (cfg_one_ff),
		.open_loop_handoff_count        (dec_handoff),
		.surge_negative_current_limit   (dec_neg),
		.surge_positive_current_limit   (dec_pos),
		.speed_detect_backemf_threshold (dec_bemf),
		.speed_detect_cycle_threshold   (dec_cyc),
		.zero_cross_open_loop_angle     (dec_angle),
		.fast_startup_rate_shift        (dec_shift)
	);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		sel         = decode(paddr);
		setup       = psel && !penable;
		access      = psel && penable && pready_ff;
		nxt_cfg_one = cfg_one_ff;
		nxt_cfg_two = cfg_two_ff;
		nxt_prdata  = prdata_ff;
		nxt_pready  = 1'b0;
		nxt_pslverr = 1'b0;
		if (setup) begin
			nxt_pready  = 1'b1;
			nxt_pslverr = (sel == 2'h0);
			if (sel == 2'h1) begin
				nxt_prdata = cfg_one_ff;
			end else if (sel == 2'h2) begin
				nxt_prdata = cfg_two_ff;
			end else begin
				nxt_prdata = tacr_pkg::RD_UNMAPPED;
			end
		end
		if (access && pwrite) begin
			if (sel == 2'h1) begin
				nxt_cfg_one = pwdata;
			end else if (sel == 2'h2) begin
				nxt_cfg_two = pwdata;
			end
		end
		nxt_handoff = dec_handoff;
		nxt_neg     = dec_neg;
		nxt_pos     = dec_pos;
		nxt_bemf    = dec_bemf;
		nxt_cyc     = dec_cyc;
		nxt_angle   = dec_angle;
		nxt_div     = 4'h1 << dec_shift;
		nxt_rate    = coeff_rate_in >> dec_shift;
		nxt_zc_en   = !open_loop_active
			|| (rotor_angle_deg > {4'h0, dec_angle});
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfg_one_ff <= tacr_pkg::RST_CFG_ONE;
			cfg_two_ff <= tacr_pkg::RST_CFG_TWO;
			prdata_ff  <= 32'h0000_0000;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			handoff_ff <= 5'h03;
			neg_ff     <= 7'sd0;
			pos_ff     <= 7'sd20;
			bemf_ff    <= 13'h0000;
			cyc_ff     <= 5'h02;
			angle_ff   <= 4'h5;
			div_ff     <= 4'h1;
			zc_en_ff   <= 1'b0;
			rate_ff    <= '0;
		end else if (ce) begin
			cfg_one_ff <= nxt_cfg_one;
			cfg_two_ff <= nxt_cfg_two;
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			handoff_ff <= nxt_handoff;
			neg_ff     <= nxt_neg;
			pos_ff     <= nxt_pos;
			bemf_ff    <= nxt_bemf;
			cyc_ff     <= nxt_cyc;
			angle_ff   <= nxt_angle;
			div_ff     <= nxt_div;
			zc_en_ff   <= nxt_zc_en;
			rate_ff    <= nxt_rate;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata                         = prdata_ff;
	assign pready                         = pready_ff;
	assign pslverr                        = pslverr_ff;
	assign trap_algorithm_config_one      = cfg_one_ff;
	assign trap_algorithm_config_two      = cfg_two_ff;
	assign open_loop_handoff_count        = handoff_ff;
	assign surge_negative_current_limit   = neg_ff;
	assign surge_positive_current_limit   = pos_ff;
	assign speed_detect_backemf_threshold = bemf_ff;
	assign speed_detect_cycle_threshold   = cyc_ff;
	assign zero_cross_open_loop_angle     = angle_ff;
	assign fast_startup_rate_divisor      = div_ff;
	assign zero_crossing_enable           = zc_en_ff;
	assign coeff_rate_scaled              = rate_ff;

endmodule

// file: sim/tacr_regs_properties.sv
`timescale 1ns/1ps
module tacr_chk #(
	parameter int ADDR_W = 12
) (
	input wire logic		clk,
	input wire logic		reset,
	input wire logic		ce,
	input wire logic		psel,
	input wire logic		penable,
	input wire logic		pwrite,
	input wire logic [ADDR_W-1:0]	paddr,
	input wire logic [31:0]		pwdata,
	input wire logic [31:0]		prdata,
	input wire logic		pready,
	input wire logic		pslverr,
	input wire logic		open_loop_active,
	input wire logic [7:0]		rotor_angle_deg,
	input wire logic [31:0]		trap_algorithm_config_one,
	input wire logic [31:0]		trap_algorithm_config_two,
	input wire logic [4:0]		open_loop_handoff_count,
	input wire logic signed [6:0]	surge_negative_current_limit,
	input wire logic signed [6:0]	surge_positive_current_limit,
	input wire logic [12:0]		speed_detect_backemf_threshold,
	input wire logic [4:0]		speed_detect_cycle_threshold,
	input wire logic [3:0]		fast_startup_rate_divisor,
	input wire logic		zero_crossing_enable
);
	localparam logic [6:0] NL [8] = '{7'h00, 7'h58, 7'h62, 7'h6c, 7'h76, 7'h0a, 7'h14, 7'h1e};
	localparam logic [3:0] AN [4] = '{4'h5, 4'h8, 4'hc, 4'hf};
	logic [31:0]	c1;
	logic [31:0]	c2;
	assign c1 = trap_algorithm_config_one;
	assign c2 = trap_algorithm_config_two;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// ----------
	// Properties
	// ----------
	sequence s_wr;
		ce && psel && penable && pready && pwrite && !pslverr
			&& paddr == tacr_pkg::ADDR_CFG_ONE;
	endsequence
	sequence s_rd;
		psel && penable && pready && !pwrite && !pslverr;
	endsequence
	property p_wr; s_wr |=> c1 == $past(pwdata); endproperty
	a_wr: assert property (p_wr) else $error("config one write lost");
	property p_rd;
		s_rd |-> prdata == (paddr == tacr_pkg::ADDR_CFG_ONE ? c1 : c2);
	endproperty
	a_rd: assert property (p_rd) else $error("read data wrong");
	property p_rst; $fell(reset) |-> c1 == 32'h0000_0000 && c2 == 32'h0020_0000; endproperty
	a_rst: assert property (p_rst) else $error("reset value wrong");
	property p_ho; ce |=> open_loop_handoff_count == 5'h03 << $past(c1[23:22]); endproperty
	a_ho: assert property (p_ho) else $error("handoff decode");
	property p_neg; ce |=> surge_negative_current_limit == NL[$past(c1[18:16])]; endproperty
	a_neg: assert property (p_neg) else $error("negative limit decode");
	property p_pos;
		ce |=> surge_positive_current_limit
			== NL[$past(c1[18:16])] + ($past(c1[15]) ? 7'h0a : 7'h14);
	endproperty
	a_pos: assert property (p_pos) else $error("positive limit decode");
	property p_bemf; ce |=> speed_detect_backemf_threshold == 13'h00c8 * $past(c1[14:10]); endproperty
	a_bemf: assert property (p_bemf) else $error("back-emf decode");
	property p_cyc; ce |=> speed_detect_cycle_threshold == 5'h02 + 5'h03 * $past(c1[9:7]); endproperty
	a_cyc: assert property (p_cyc) else $error("cycle decode");
	property p_zc;
		ce && $stable(c1) && c1 == $past(c1, 2) |=> zero_crossing_enable
			== (!$past(open_loop_active) || $past(rotor_angle_deg) > AN[$past(c1[3:2])]);
	endproperty
	a_zc: assert property (p_zc) else $error("zero-cross enable");
	property p_div; ce |=> fast_startup_rate_divisor == 4'h1 << $past(c1[1:0]); endproperty
	a_div: assert property (p_div) else $error("divisor decode");
	property p_frz;
		!ce |=> $stable(c1) && $stable(c2) && $stable(prdata) && $stable(pready)
			&& $stable(zero_crossing_enable) && $stable(fast_startup_rate_divisor);
	endproperty
	a_frz: assert property (p_frz) else $error("clock enable freeze");
endmodule
bind tacr_regs tacr_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
	logic			clk, reset, ce, psel, penable, pwrite, pready, pslverr, e;
	logic			open_loop_active, zero_crossing_enable;
	logic [11:0]		paddr;
	logic [31:0]		pwdata, prdata, trap_algorithm_config_one, trap_algorithm_config_two, w, r;
	logic [7:0]		rotor_angle_deg;
	logic [15:0]		coeff_rate_in, coeff_rate_scaled;
	logic [4:0]		open_loop_handoff_count, speed_detect_cycle_threshold;
	logic signed [6:0]	surge_negative_current_limit, surge_positive_current_limit;
	logic [12:0]		speed_detect_backemf_threshold;
	logic [3:0]		zero_cross_open_loop_angle, fast_startup_rate_divisor;
	int			num_errors = 0, n_checks = 0, seed = 32'h0000_fd7c, i;
	localparam logic signed [6:0] NL [8] = '{7'h00, 7'h58, 7'h62, 7'h6c, 7'h76, 7'h0a, 7'h14, 7'h1e};
	localparam logic [3:0] AN [4] = '{4'h5, 4'h8, 4'hc, 4'hf};

	tacr_regs #(.ADDR_W(12), .RATE_W(16)) dut (.*);

	always #5 clk = ~clk;
	// ----------
	// Tasks
	// ----------
	task chk(input string n, input logic [31:0] x, input logic [31:0] s);
		n_checks++;
		if (s !== x) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		{psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		r = prdata;
		e = pslverr;
		if (pready !== 1'b1) num_errors++;
		{psel, penable} <= 2'b00;
		@(posedge clk);
	endtask
	function automatic logic [31:0] exp_pos(input logic [31:0] c);
		return NL[c[18:16]] + (c[15] ? 7'sh0a : 7'sh14);
	endfunction
	task dec;
		logic [31:0] c;
		c = trap_algorithm_config_one;
		chk("handoff", 5'h03 << c[23:22], open_loop_handoff_count);
		chk("neg", NL[c[18:16]], surge_negative_current_limit);
		chk("pos", exp_pos(c), surge_positive_current_limit);
		chk("bemf", 13'h00c8 * c[14:10], speed_detect_backemf_threshold);
		chk("cycle", 5'h02 + 5'h03 * c[9:7], speed_detect_cycle_threshold);
		chk("angle", AN[c[3:2]], zero_cross_open_loop_angle);
		chk("zc_en", !open_loop_active || rotor_angle_deg > AN[c[3:2]], zero_crossing_enable);
		chk("div", 4'h1 << c[1:0], fast_startup_rate_divisor);
		chk("rate", coeff_rate_in >> c[1:0], coeff_rate_scaled);
	endtask
	task rst_test;
		reset <= 1'b1;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		apb(1'b0, tacr_pkg::ADDR_CFG_ONE, 32'h0000_0000);
		chk("rst_one", 32'h0000_0000, r);
		apb(1'b0, tacr_pkg::ADDR_CFG_TWO, 32'h0000_0000);
		chk("rst_two", 32'h0020_0000, r);
		dec;
		$display("reset test done");
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// ----------
	// Sequence
	// ----------
	initial begin
		{clk, reset, ce, psel, penable, pwrite, open_loop_active} = 7'b0110000;
		{paddr, pwdata, rotor_angle_deg, coeff_rate_in} = '0;
		rst_test;
		for (i = 0; i < 40; i++) begin
			w = $random(seed);
			if (i < 8) w = 32'({11{i[2:0]}});
			else if (i == 8) w = 32'hffff_ffff;
			apb(1'b1, tacr_pkg::ADDR_CFG_ONE, w);
			apb(1'b0, tacr_pkg::ADDR_CFG_ONE, 32'h0000_0000);
			chk("cfg_one", w, r);
			chk("cfg_err", 32'h0000_0000, e);
			apb(1'b1, tacr_pkg::ADDR_CFG_TWO, ~w);
			apb(1'b0, tacr_pkg::ADDR_CFG_TWO, 32'h0000_0000);
			chk("cfg_two", ~w, r);
			{open_loop_active, rotor_angle_deg, coeff_rate_in} <= 25'($random(seed)) & 25'h11f_ffff;
			repeat (2) @(posedge clk);
			dec;
		end
		r = {15'h0000, zero_crossing_enable, coeff_rate_scaled};
		ce <= 1'b0;
		{open_loop_active, rotor_angle_deg, coeff_rate_in} <= ~{open_loop_active, rotor_angle_deg,
			coeff_rate_in};
		repeat (3) @(posedge clk);
		chk("frozen", r, {15'h0000, zero_crossing_enable, coeff_rate_scaled});
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		dec;
		$display("random test done");
		apb(1'b1, 12'h004, 32'h0000_0000);
		chk("err_wr", 32'h0000_0001, e);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk("err_rd", 32'h0000_0001, e);
		chk("err_data", 32'h0000_0000, r);
		apb(1'b0, tacr_pkg::ADDR_CFG_ONE, 32'h0000_0000);
		chk("kept", w, r);
		$display("unmapped test done");
		rst_test;
		stop_test;
	end
	initial begin
		#50000;
		num_errors++;
		stop_test;
	end
endmodule
